// ==== control_and_led_blink_regs.sv ====
// Control and Led_blink_config bank with reset pulse, mode and LED blink logic
`timescale 1ns/1ps

// What this block does
// - Control bits 7:4 mask sense inputs 7:4.
// - Control bits 3:2 pick reset pulse width.
// - Control bit 1 drives regulator switch output in run mode.
// - Run-entry bit 0 only clearable by software.
// - Cleared run bit means standby state outputs.
// - Reset pulse rising edge enters run mode.
// - LED bits 7:6 select ground, rail, blink.
// - LED bit 4 clears error counter; bit5 unused.
// - LED bits 3:2 select blink low time.
// - LED bits 1:0 select blink on duration.
module control_and_led_blink_regs (
  input wire logic clk_sys, // System clock, 10 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic osc_tick, // One-cycle pulse per oscillator period
  input wire onoff_regs_pkg::reg_wr_t reg_wr, // Register write from bus front end
  input wire logic [7:0] rd_addr, // Register read address
  output logic [7:0] rd_data, // Registered read data
  input wire logic [7:0] sense_inputs, // Conditioned sense inputs
  input wire logic info_ack, // Host has taken change information
  input wire logic reset_req, // Wake event asking for a reset pulse
  output logic reset_pulse_out, // Reset pulse, low while active
  output logic onoff_out, // Regulator switch output
  output logic change_info_out, // Change info level, active low
  output logic change_info_oe_n, // Change info drive enable, active low
  output logic watchdog_en, // Watchdog enabled in run mode
  output logic reset_gen_en, // Reset generation enabled in standby
  output logic led_out, // LED drive
  output logic err_cnt_clr // One-cycle clear of bus error counter
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [7:0] ctrl_q;
  logic [7:0] led_q;
  logic [7:0] sense_q;
  logic chi_low_q;
  logic rp_active_q;
  logic [onoff_regs_pkg::CNT_W-1:0] rp_cnt_q;
  logic rp_rise;
  logic ctrl_wr;
  logic led_wr;
  logic [onoff_regs_pkg::CNT_W-1:0] rp_ticks;
  logic [onoff_regs_pkg::CNT_W-1:0] low_ticks;
  logic [onoff_regs_pkg::CNT_W-1:0] dur_ticks;
  logic [7:0] unmasked;
  logic run;
  onoff_regs_pkg::blink_state_t blink_q;
  logic [onoff_regs_pkg::CNT_W-1:0] blink_cnt_q;
  logic [1:0] led_mode;

  // Address decode of the write port
  always_comb begin
    ctrl_wr = 1'b0;
    led_wr = 1'b0;
    if (reg_wr.en && reg_wr.addr == onoff_regs_pkg::CTRL_OFS) begin
      ctrl_wr = 1'b1;
    end else if (reg_wr.en && reg_wr.addr == onoff_regs_pkg::LED_OFS) begin
      led_wr = 1'b1;
    end
  end

  assign run = ctrl_q[onoff_regs_pkg::CTRL_RUN];
  assign led_mode = led_q[onoff_regs_pkg::LED_MODE_HI:onoff_regs_pkg::LED_MODE_LO];

  //////////////////////////////////////////////////////////////////////////////
  // Control register

  // Pulse ends (output rises) on this cycle
  assign rp_rise = rp_active_q && osc_tick && (rp_cnt_q <= onoff_regs_pkg::CNT_W'(1));

  // Mask, width and switch bits store plainly; run bit is clear-only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= onoff_regs_pkg::CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_q[onoff_regs_pkg::CTRL_MASK_HI:onoff_regs_pkg::CTRL_ONOFF] <=
          reg_wr.data[onoff_regs_pkg::CTRL_MASK_HI:onoff_regs_pkg::CTRL_ONOFF];
      end
      // rise sets run
      // Setting from the pulse wins over a same-cycle software clear
      if (rp_rise) begin
        ctrl_q[onoff_regs_pkg::CTRL_RUN] <= 1'b1;
      end else if (ctrl_wr && !reg_wr.data[onoff_regs_pkg::CTRL_RUN]) begin
        ctrl_q[onoff_regs_pkg::CTRL_RUN] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Led_blink_config

  // Error-counter clear bit is a strobe, never stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      led_q <= onoff_regs_pkg::LED_RST;
      err_cnt_clr <= 1'b0;
    end else begin
      if (led_wr) begin
        led_q <= reg_wr.data & ~(8'h01 << onoff_regs_pkg::LED_ERRCLR);
      end
      err_cnt_clr <= led_wr && reg_wr.data[onoff_regs_pkg::LED_ERRCLR];
    end
  end

  // Read port; unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_addr == onoff_regs_pkg::CTRL_OFS) begin
      rd_data <= ctrl_q;
    end else if (rd_addr == onoff_regs_pkg::LED_OFS) begin
      rd_data <= led_q;
    end else begin
      rd_data <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset pulse generation

  always_comb begin
    case (ctrl_q[onoff_regs_pkg::CTRL_RPW_HI:onoff_regs_pkg::CTRL_RPW_LO])
      2'h0: rp_ticks = onoff_regs_pkg::ms_to_ticks(onoff_regs_pkg::RPW_00_MS);
      2'h1: rp_ticks = onoff_regs_pkg::ms_to_ticks(onoff_regs_pkg::RPW_01_MS);
      2'h2: rp_ticks = onoff_regs_pkg::ms_to_ticks(onoff_regs_pkg::RPW_10_MS);
      default: rp_ticks = onoff_regs_pkg::ms_to_ticks(onoff_regs_pkg::RPW_11_MS);
    endcase
  end

  // Pulse only starts in standby; width is latched at start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rp_active_q <= 1'b0;
      rp_cnt_q <= '0;
    end else if (rp_active_q) begin
      if (rp_rise) begin
        rp_active_q <= 1'b0;
      end else if (osc_tick) begin
        rp_cnt_q <= rp_cnt_q - onoff_regs_pkg::CNT_W'(1);
      end
    end else if (!run && reset_req) begin
      rp_active_q <= 1'b1;
      rp_cnt_q <= rp_ticks;
    end
  end

  assign reset_pulse_out = ~rp_active_q;

  //////////////////////////////////////////////////////////////////////////////
  // Mode outputs and change information

  assign watchdog_en = run;
  assign reset_gen_en = ~run;
  assign change_info_oe_n = ~run;
  assign onoff_out = run & ctrl_q[onoff_regs_pkg::CTRL_ONOFF];
  assign change_info_out = ~chi_low_q;

  assign unmasked = {~ctrl_q[onoff_regs_pkg::CTRL_MASK_HI:onoff_regs_pkg::CTRL_MASK_LO], 4'hf};

  // Change latches low until the host acknowledges; a new change beats the ack
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sense_q <= 8'h00;
      chi_low_q <= 1'b1;
    end else begin
      sense_q <= sense_inputs;
      if (|((sense_q ^ sense_inputs) & unmasked)) begin
        chi_low_q <= 1'b1;
      end else if (info_ack) begin
        chi_low_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // LED blinker

  always_comb begin
    case (led_q[onoff_regs_pkg::LED_LOW_HI:onoff_regs_pkg::LED_LOW_LO])
      2'h0: low_ticks = onoff_regs_pkg::ms_to_ticks(onoff_regs_pkg::LOW_00_MS);
      2'h1: low_ticks = onoff_regs_pkg::ms_to_ticks(onoff_regs_pkg::LOW_01_MS);
      2'h2: low_ticks = onoff_regs_pkg::ms_to_ticks(onoff_regs_pkg::LOW_10_MS);
      default: low_ticks = onoff_regs_pkg::ms_to_ticks(onoff_regs_pkg::LOW_11_MS);
    endcase
  end

  always_comb begin
    case (led_q[onoff_regs_pkg::LED_DUR_HI:onoff_regs_pkg::LED_DUR_LO])
      2'h0: dur_ticks = onoff_regs_pkg::ms_to_ticks(onoff_regs_pkg::DUR_00_MS);
      2'h1: dur_ticks = onoff_regs_pkg::ms_to_ticks(onoff_regs_pkg::DUR_01_MS);
      2'h2: dur_ticks = onoff_regs_pkg::ms_to_ticks(onoff_regs_pkg::DUR_10_MS);
      default: dur_ticks = onoff_regs_pkg::ms_to_ticks(onoff_regs_pkg::DUR_11_MS);
    endcase
  end

  // on then off cycle
  // Held in the on phase start while not blinking, so a new blink starts lit
  always_ff @(posedge clk_sys) begin
    if (rst || !led_mode[onoff_regs_pkg::LED_MODE_BLINK_BIT]) begin
      blink_q <= onoff_regs_pkg::BLINK_ON;
      blink_cnt_q <= '0;
    end else if (osc_tick) begin
      case (blink_q)
        onoff_regs_pkg::BLINK_ON: begin
          if (blink_cnt_q + onoff_regs_pkg::CNT_W'(1) >= dur_ticks) begin
            blink_q <= onoff_regs_pkg::BLINK_OFF;
            blink_cnt_q <= '0;
          end else begin
            blink_cnt_q <= blink_cnt_q + onoff_regs_pkg::CNT_W'(1);
          end
        end
        default: begin
          if (blink_cnt_q + onoff_regs_pkg::CNT_W'(1) >= low_ticks) begin
            blink_q <= onoff_regs_pkg::BLINK_ON;
            blink_cnt_q <= '0;
          end else begin
            blink_cnt_q <= blink_cnt_q + onoff_regs_pkg::CNT_W'(1);
          end
        end
      endcase
    end
  end

  // LED mode select
  // Registered so the pin never glitches on a mode write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      led_out <= 1'b0;
    end else if (led_mode[onoff_regs_pkg::LED_MODE_BLINK_BIT]) begin
      led_out <= (blink_q == onoff_regs_pkg::BLINK_ON);
    end else begin
      led_out <= (led_mode == onoff_regs_pkg::LED_MODE_VDD);
    end
  end

endmodule // control_and_led_blink_regs

// ==== onoff_regs_pkg.sv ====
// Package: offsets, fields, reset values and timing for the control and Led_blink_config bank
package onoff_regs_pkg;

  // Local register offsets on the write/read port
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LED_OFS = 8'h01;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h03;
  localparam logic [7:0] LED_RST = 8'h04;

  // Control register fields
  localparam int CTRL_MASK_HI = 7;
  localparam int CTRL_MASK_LO = 4;
  localparam int CTRL_RPW_HI = 3;
  localparam int CTRL_RPW_LO = 2;
  localparam int CTRL_ONOFF = 1;
  localparam int CTRL_RUN = 0;

  // Led_blink_config fields
  localparam int LED_MODE_HI = 7;
  localparam int LED_MODE_LO = 6;
  localparam int LED_ERRCLR = 4;
  localparam int LED_LOW_HI = 3;
  localparam int LED_LOW_LO = 2;
  localparam int LED_DUR_HI = 1;
  localparam int LED_DUR_LO = 0;

  // LED mode codes; bit 6 set selects blinking
  localparam logic [1:0] LED_MODE_GND = 2'h0;
  localparam logic [1:0] LED_MODE_VDD = 2'h2;
  localparam int LED_MODE_BLINK_BIT = 0;

  // Timing base: slow oscillator rate
  localparam int OSC_HZ = 32768;
  localparam int CNT_W = 17;

  // Reset pulse widths in ms
  localparam int RPW_00_MS = 20;
  localparam int RPW_01_MS = 10;
  localparam int RPW_10_MS = 5;
  localparam int RPW_11_MS = 1;
  // LED low times in ms
  localparam int LOW_00_MS = 500;
  localparam int LOW_01_MS = 1000;
  localparam int LOW_10_MS = 1500;
  localparam int LOW_11_MS = 2000;
  // LED on durations in ms
  localparam int DUR_00_MS = 20;
  localparam int DUR_01_MS = 30;
  localparam int DUR_10_MS = 40;
  localparam int DUR_11_MS = 50;

  // Milliseconds to oscillator ticks, at least one tick
  function automatic logic [CNT_W-1:0] ms_to_ticks(input int ms);
    int t;
    t = (ms * OSC_HZ) / 1000;
    if (t < 1) begin
      t = 1;
    end
    return CNT_W'(t);
  endfunction

  // Write request carrier
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  // LED blink phases, one-hot
  typedef enum logic [1:0] {
    BLINK_ON = 2'b01,
    BLINK_OFF = 2'b10
  } blink_state_t;

endpackage

// ==== osc_tick_src.sv ====
// Slow oscillator model feeding one-cycle ticks to the bank
`timescale 1ns/1ps
module osc_tick_src #(
  parameter int DIV = 2 // System cycles per tick, 2 or more
) (
  input wire logic clk_sys, // System clock
  output logic osc_tick // One-cycle tick
);
  int cnt = 0;
  initial osc_tick = 1'b0;
  // Tick moves off the sampling edge; DIV of 2 keeps ticks apart for exact counts
  always @(negedge clk_sys) begin
    cnt = (cnt + 1) % DIV;
    osc_tick <= (cnt == 0);
  end
endmodule // osc_tick_src

// ==== onoff_regs_chk.sv ====
// Port checker for the control and Led_blink_config bank
`timescale 1ns/1ps
module onoff_regs_chk (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic osc_tick, // Timing tick
  input wire onoff_regs_pkg::reg_wr_t reg_wr, // Write request
  input wire logic reset_req, // Wake event
  input wire logic reset_pulse_out, // Pulse, low active
  input wire logic onoff_out, // Switch output
  input wire logic change_info_oe_n, // Drive enable
  input wire logic watchdog_en, // Run mode
  input wire logic reset_gen_en, // Standby
  input wire logic err_cnt_clr // Counter clear
);
  logic clr_wr; // LED write with clear bit
  logic run_clr; // Control write clearing run bit
  assign clr_wr = reg_wr.en && reg_wr.addr == 8'h01 && reg_wr.data[4];
  assign run_clr = reg_wr.en && reg_wr.addr == 8'h00 && !reg_wr.data[0];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A one-edge reset also raises run; those edges are left out
  AST_STBY: assert property (reset_gen_en |-> !onoff_out && change_info_oe_n && !watchdog_en)
    else $error("standby outputs wrong");
  AST_RUN: assert property (watchdog_en |-> !change_info_oe_n && !reset_gen_en)
    else $error("run outputs wrong");
  AST_CLR: assert property (run_clr && reset_pulse_out |=> reset_gen_en)
    else $error("run bit not cleared");
  AST_ENTRY: assert property ($rose(watchdog_en) && !$past(rst) |-> $rose(reset_pulse_out))
    else $error("run entered without pulse end");
  AST_WAKE: assert property (reset_req && reset_pulse_out && reset_gen_en |=> !reset_pulse_out)
    else $error("wake did not start pulse");
  AST_LOWSTBY: assert property (!reset_pulse_out |-> reset_gen_en)
    else $error("pulse outside standby");
  AST_TICK: assert property ($rose(reset_pulse_out) && !$past(rst) |-> $past(osc_tick))
    else $error("pulse ended off a tick");
  AST_ERR: assert property (clr_wr |=> err_cnt_clr)
    else $error("no counter clear");
  AST_ERRSRC: assert property (err_cnt_clr |-> $past(clr_wr))
    else $error("stray counter clear");
endmodule // onoff_regs_chk

// ==== control_and_led_blink_regs_tb.sv ====
// Self-checking bench for the control and Led_blink_config bank
`timescale 1ns/1ps
module control_and_led_blink_regs_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic osc_tick, info_ack = 1'b0, reset_req = 1'b0;
  onoff_regs_pkg::reg_wr_t reg_wr = '0;
  logic [7:0] rd_addr = 8'h00, sense_inputs = 8'h00, rd_data;
  logic reset_pulse_out, onoff_out, change_info_out, change_info_oe_n;
  logic watchdog_en, reset_gen_en, led_out, err_cnt_clr;
  int err_count = 0, compares = 0, tick_cnt = 0, snap = 0;
  int rpw[4] = '{655, 327, 163, 32};
  int dur[4] = '{655, 983, 1310, 1638};
  control_and_led_blink_regs control_and_led_blink_regs_inst (.clk_sys(clk_sys), .rst(rst),
    .osc_tick(osc_tick), .reg_wr(reg_wr), .rd_addr(rd_addr), .rd_data(rd_data), .sense_inputs(sense_inputs),
    .info_ack(info_ack), .reset_req(reset_req), .reset_pulse_out(reset_pulse_out), .onoff_out(onoff_out),
    .change_info_out(change_info_out), .change_info_oe_n(change_info_oe_n), .watchdog_en(watchdog_en),
    .reset_gen_en(reset_gen_en), .led_out(led_out), .err_cnt_clr(err_cnt_clr));
  osc_tick_src #(.DIV(2)) osc_tick_src_inst (.clk_sys(clk_sys), .osc_tick(osc_tick));
  initial forever #50 clk_sys = ~clk_sys;
  // Running tick count, so widths are differences of two snapshots
  always @(posedge clk_sys) if (osc_tick) tick_cnt <= tick_cnt + 1;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = '{1'b1, a, d};
    @(negedge clk_sys);
    reg_wr.en = 1'b0;
    snap = tick_cnt;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    rd_addr = a;
    @(negedge clk_sys);
    chk("rd_data", rd_data, e);
  endtask
  // Bounded wait for pulse (s=1) or LED (s=0) level
  task automatic wt(input int s, input logic v);
    for (int n = 0; n < 80000 && (s ? reset_pulse_out : led_out) !== v; n++) @(negedge clk_sys);
    // A wait that runs out is a mismatch in its own right
    if ((s ? reset_pulse_out : led_out) !== v) begin
      err_count++;
      $display("BAD wait_level expected %0h seen %0h", v, (s ? reset_pulse_out : led_out));
    end
  endtask
  task automatic sense(input logic [7:0] v, input logic e);
    @(negedge clk_sys);
    sense_inputs = v;
    repeat (3) @(negedge clk_sys);
    chk("change_info_out", change_info_out, e);
  endtask
  task automatic ack();
    @(negedge clk_sys);
    info_ack = 1'b1;
    @(negedge clk_sys);
    info_ack = 1'b0;
  endtask
  task automatic summarize();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    rd(8'h00, 8'h03);
    rd(8'h01, 8'h04);
    rd(8'h05, 8'h00);
    wr(8'h00, 8'h01);
    chk("onoff_out", onoff_out, 1'b0);
    wr(8'h01, 8'h10);
    // Clear strobe stands only in the cycle right after the write edge
    chk("err_cnt_clr", err_cnt_clr, 1'b1);
    @(negedge clk_sys);
    chk("err_cnt_clr", err_cnt_clr, 1'b0);
    rd(8'h01, 8'h00);
    wr(8'h01, 8'h80);
    @(negedge clk_sys);
    chk("led_out", led_out, 1'b1);
    // Upper inputs masked, then unmasked
    wr(8'h00, 8'hf3);
    ack();
    sense(8'hf0, 1'b1);
    sense(8'hf8, 1'b0);
    ack();
    wr(8'h00, 8'h03);
    sense(8'he8, 1'b0);
    // Standby, refused set, then wake pulse of each width
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {4'h0, 2'(i), 2'b10});
      chk("standby", {watchdog_en, reset_gen_en, onoff_out, change_info_oe_n}, 4'h5);
      wr(8'h00, {4'h0, 2'(i), 2'b11});
      chk("watchdog_en", watchdog_en, 1'b0);
      @(negedge clk_sys);
      reset_req = 1'b1;
      @(negedge clk_sys);
      reset_req = 1'b0;
      snap = tick_cnt;
      wt(1, 1'b1);
      chk("pulse_ticks", tick_cnt - snap, rpw[i]);
      chk("run", {watchdog_en, onoff_out, change_info_oe_n}, 3'b110);
    end
    // Blink on time per code, one low phase; ground restarts
    for (int i = 0; i < 4; i++) begin
      wr(8'h01, {i[0], 1'b1, 4'h0, 2'(i)});
      wt(0, 1'b1);
      wt(0, 1'b0);
      chk("on_ticks", tick_cnt - snap, dur[i]);
      if (i == 0) begin
        snap = tick_cnt;
        wt(0, 1'b1);
        chk("low_ticks", tick_cnt - snap, 16384);
      end
      wr(8'h01, 8'h00);
      @(negedge clk_sys);
      chk("led_gnd", led_out, 1'b0);
    end
    summarize();
  end
  // Hang guard, about twice the expected run
  initial begin
    repeat (90000) @(negedge clk_sys);
    err_count++;
    summarize();
  end
endmodule // control_and_led_blink_regs_tb
bind control_and_led_blink_regs onoff_regs_chk onoff_regs_chk_inst (.clk_sys(clk_sys), .rst(rst),
  .osc_tick(osc_tick), .reg_wr(reg_wr), .reset_req(reset_req), .reset_pulse_out(reset_pulse_out),
  .onoff_out(onoff_out), .change_info_oe_n(change_info_oe_n), .watchdog_en(watchdog_en),
  .reset_gen_en(reset_gen_en), .err_cnt_clr(err_cnt_clr));
